// >>> bench/spcr_link_model.sv
// Downstream link partner: reports link states and answers turn-off requests
`timescale 1ns/1ps
module spcr_link_model (
  input  wire       clk_in,     // Core clock
  input  wire       rst_b_in,   // Reset, active low
  input  wire [1:0] req_in,     // Turn-off requests
  input  wire [3:0] wait_in,    // Reply delay in cycles
  input  wire [3:0] state_in,   // Link states to report
  output reg  [1:0] sent_out,   // Turn-off sent pulses
  output wire [3:0] pstate_out  // Link power states
);
  reg [3:0] cnt_q [0:1];
  integer   i;
  assign pstate_out = state_in;
  always @(posedge clk_in or negedge rst_b_in) begin
    for (i = 0; i < 2; i = i + 1) begin
      if (!rst_b_in) begin
        cnt_q[i] <= 4'h0;
        sent_out[i] <= 1'b0;
      end else begin
        sent_out[i] <= req_in[i] && !sent_out[i] && cnt_q[i] == wait_in;
        cnt_q[i] <= (req_in[i] && !sent_out[i] && cnt_q[i] != wait_in) ? cnt_q[i] + 4'h1 : 4'h0;
      end
    end
  end
endmodule

// >>> bench/spcr_regs_bank_sva.sv
// Concurrent checks on the port configuration bank ports
`timescale 1ns/1ps
module spcr_regs_bank_sva #(
  parameter NDS = 2,                                   // Downstream ports
  parameter PW  = 2                                    // Port selector width
) (
  input wire              clk_in, rst_b_in,            // Clock, reset active low
  input wire              cfg_req_in, cfg_we_in,       // Access request and direction
  input wire [PW-1:0]     cfg_port_in,                 // Access port
  input wire [7:0]        cfg_addr_in,                 // Access offset
  input wire [3:0]        cfg_be_in,                   // Byte enables
  input wire [31:0]       cfg_wdata_in, cfg_rdata_out, // Write and read data
  input wire [2*NDS-1:0]  link_pstate_in,              // Link states
  input wire [NDS-1:0]    pme_turnoff_sent_in,         // Turn-off sent
  input wire              cfg_ack_out,                 // Access done
  input wire [NDS-1:0]    port_power_gpio_out, dev_reset_b_out, pme_turnoff_req_out // Port pins
);
  wire wr1 = cfg_req_in && cfg_we_in && cfg_port_in == 1 && cfg_addr_in == 8'h9c && cfg_be_in[0];
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_wr1; wr1; endsequence
  sequence s_rd(a); cfg_req_in && !cfg_we_in && cfg_addr_in == a; endsequence
  a_ack_next: assert property (cfg_req_in |=> cfg_ack_out)
    else $error("ack missing");
  a_ack_cause: assert property (cfg_ack_out |-> $past(cfg_req_in))
    else $error("ack without request");
  a_rdata_hold: assert property (!(cfg_req_in && !cfg_we_in) |=> $stable(cfg_rdata_out))
    else $error("read data moved without read");
  a_margin_rsvd: assert property (s_rd(8'h94) |=> cfg_rdata_out[31:16] == 16'h0)
    else $error("margin upper bits not zero");
  a_mode_fixed: assert property (s_rd(8'h98) |=> cfg_rdata_out[15:0] == 16'h0122 && cfg_rdata_out[31:28] == 4'h0)
    else $error("mode word wrong");
  a_link_copy: assert property (s_rd(8'h9c) ##0 cfg_port_in == 1 && $past(rst_b_in) |=>
    cfg_rdata_out[17:16] == $past(link_pstate_in[1:0], 2) && cfg_rdata_out[15:4] == 12'h0)
    else $error("link state read wrong");
  a_toff_set: assert property (s_wr1 ##0 cfg_wdata_in[1] && !pme_turnoff_sent_in[0] |-> ##2 pme_turnoff_req_out[0])
    else $error("turn-off request not raised");
  a_toff_clear: assert property (pme_turnoff_sent_in[0] && !(wr1 && cfg_wdata_in[1]) |-> ##2 !pme_turnoff_req_out[0])
    else $error("turn-off request not cleared");
  a_reset_pin: assert property (s_wr1 |-> ##2 dev_reset_b_out[0] == $past(cfg_wdata_in[3], 2))
    else $error("device reset pin wrong");
  a_power_pin: assert property (s_wr1 ##0 cfg_wdata_in[2] |-> ##2 port_power_gpio_out[0])
    else $error("port power pin wrong");
  a_toff_withdraw: assert property (s_wr1 ##0 !cfg_wdata_in[1] |-> ##2 !pme_turnoff_req_out[0])
    else $error("turn-off request not withdrawn");
endmodule
bind spcr_regs_bank spcr_regs_bank_sva #(.NDS(NDS), .PW(PW)) u_sva (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .cfg_req_in(cfg_req_in), .cfg_we_in(cfg_we_in),
  .cfg_port_in(cfg_port_in), .cfg_addr_in(cfg_addr_in), .cfg_be_in(cfg_be_in), .cfg_wdata_in(cfg_wdata_in),
  .cfg_rdata_out(cfg_rdata_out), .link_pstate_in(link_pstate_in), .pme_turnoff_sent_in(pme_turnoff_sent_in),
  .cfg_ack_out(cfg_ack_out), .port_power_gpio_out(port_power_gpio_out), .dev_reset_b_out(dev_reset_b_out),
  .pme_turnoff_req_out(pme_turnoff_req_out));

// >>> bench/spcr_regs_bank_tb_top.sv
// Self-checking testbench of the port configuration register bank
`timescale 1ns/1ps
module spcr_regs_bank_tb_top;
  reg         clk_in = 1'b0, rst_b_in = 1'b0, req = 1'b0, we = 1'b0, ldv = 1'b0, strap = 1'b0;
  reg  [1:0]  port = 2'h0, ldp = 2'h0;
  reg  [7:0]  addr = 8'h00, lda = 8'h00;
  reg  [3:0]  be = 4'hf, dly = 4'h0, st = 4'h0;
  reg  [31:0] wd = 32'h0, ldd = 32'h0, r;
  wire        ack;
  wire [31:0] rd;
  wire [6:0]  clk_en;
  wire [1:0]  gpio, drst_b, toff, sent;
  wire [3:0]  pst;
  integer     mismatches = 0, checked = 0, i;
  spcr_regs_bank dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .cfg_req_in(req), .cfg_we_in(we), .cfg_port_in(port),
    .cfg_addr_in(addr), .cfg_be_in(be), .cfg_wdata_in(wd), .ld_valid_in(ldv), .ld_port_in(ldp), .ld_addr_in(lda),
    .ld_data_in(ldd), .clock_buffer_powerdown_strap_in(strap), .link_pstate_in(pst), .pme_turnoff_sent_in(sent),
    .cfg_ack_out(ack), .cfg_rdata_out(rd), .ref_clock_out_pairs_en_out(clk_en), .port_power_gpio_out(gpio),
    .dev_reset_b_out(drst_b), .pme_turnoff_req_out(toff));
  spcr_link_model far (.clk_in(clk_in), .rst_b_in(rst_b_in), .req_in(toff), .wait_in(dly), .state_in(st),
    .sent_out(sent), .pstate_out(pst));
  initial forever #2 clk_in = ~clk_in;
  task close_out;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task acc(input [1:0] p, input w, input [7:0] a, input [31:0] d);
    begin
      @(negedge clk_in);
      {req, we, port, addr, wd} = {1'b1, w, p, a, d};
      @(negedge clk_in);
      req = 1'b0;
      chk("ack", {31'h0, ack}, 32'h1);
      r = rd;
    end
  endtask
  task rdc(input string nm, input [1:0] p, input [7:0] a, input [31:0] exp);
    begin
      acc(p, 1'b0, a, 32'h0);
      chk(nm, r, exp);
    end
  endtask
  task ld(input [1:0] p, input [7:0] a, input [31:0] d);
    begin
      @(negedge clk_in);
      {ldv, ldp, lda, ldd} = {1'b1, p, a, d};
      @(negedge clk_in);
      ldv = 1'b0;
    end
  endtask
  task pins(input [6:0] e, input [1:0] g, input [1:0] rb);
    begin
      repeat (2) @(negedge clk_in);
      chk("clock enables", {25'h0, clk_en}, {25'h0, e});
      chk("port power", {30'h0, gpio}, {30'h0, g});
      chk("device reset", {30'h0, drst_b}, {30'h0, rb});
    end
  endtask
  task do_reset(input s);
    begin
      rst_b_in = 1'b0;
      strap = s;
      repeat (16) @(negedge clk_in);
      rst_b_in = 1'b1;
      repeat (8) @(negedge clk_in);
    end
  endtask
  task t_reset;
    begin
      rdc("margin", 2'h0, 8'h94, 32'h0000116b);
      rdc("mode", 2'h0, 8'h98, 32'h001f0122);
      rdc("pme p1", 2'h1, 8'h9c, 32'h0000000d);
      rdc("margin p1", 2'h1, 8'h94, 32'h0);
      rdc("pme p0", 2'h0, 8'h9c, 32'h0);
      rdc("unmapped", 2'h3, 8'ha0, 32'h0);
      pins(7'h1f, 2'h3, 2'h3);
      $display("test reset done");
    end
  endtask
  task t_write;
    begin
      acc(2'h0, 1'b1, 8'h94, 32'hffffffff);
      acc(2'h0, 1'b1, 8'h98, 32'hffffffff);
      rdc("margin ro", 2'h0, 8'h94, 32'h0000116b);
      rdc("mode ro", 2'h0, 8'h98, 32'h001f0122);
      be = 4'he;
      acc(2'h1, 1'b1, 8'h9c, 32'h0);
      be = 4'hf;
      rdc("be ignored", 2'h1, 8'h9c, 32'h0000000d);
      acc(2'h1, 1'b1, 8'h9c, 32'hfffffff1);
      rdc("pme p1 low", 2'h1, 8'h9c, 32'h00000001);
      pins(7'h1f, 2'h2, 2'h2);
      acc(2'h2, 1'b1, 8'h9c, 32'h0);
      pins(7'h1f, 2'h0, 2'h0);
      acc(2'h1, 1'b1, 8'h9c, 32'hc);
      acc(2'h2, 1'b1, 8'h9c, 32'hc);
      pins(7'h1f, 2'h3, 2'h3);
      $display("test write done");
    end
  endtask
  task t_turnoff;
    begin
      dly = 4'h6;
      acc(2'h1, 1'b1, 8'h9c, 32'he);
      @(negedge clk_in);
      chk("turnoff req", {30'h0, toff}, 32'h1);
      i = 0;
      while (toff[0] && i < 40) begin
        @(negedge clk_in);
        i = i + 1;
      end
      chk("turnoff cleared", {30'h0, toff}, 32'h0);
      rdc("pme p1 done", 2'h1, 8'h9c, 32'h0000000d);
      dly = 4'hf;
      acc(2'h1, 1'b1, 8'h9c, 32'he);
      acc(2'h1, 1'b1, 8'h9c, 32'hc);
      repeat (2) @(negedge clk_in);
      chk("turnoff withdrawn", {30'h0, toff}, 32'h0);
      rdc("pme p1 withdrawn", 2'h1, 8'h9c, 32'h0000000d);
      dly = 4'h0;
      acc(2'h2, 1'b1, 8'h9c, 32'he);
      @(negedge clk_in);
      chk("turnoff req p2", {30'h0, toff}, 32'h2);
      repeat (6) @(negedge clk_in);
      rdc("pme p2 done", 2'h2, 8'h9c, 32'h0000000d);
      $display("test turnoff done");
    end
  endtask
  task t_link;
    integer c;
    begin
      for (c = 0; c < 4; c = c + 1) begin
        st = {2'h3 - c[1:0], c[1:0]};
        repeat (2) @(negedge clk_in);
        rdc("link p1", 2'h1, 8'h9c, {14'h0, c[1:0], 16'h000d});
        rdc("link p2", 2'h2, 8'h9c, {14'h0, 2'h3 - c[1:0], 16'h000d});
      end
      st = 4'h0;
      $display("test link done");
    end
  endtask
  task t_load;
    begin
      ld(2'h0, 8'h94, 32'h12345678);
      rdc("margin load", 2'h0, 8'h94, 32'h00005678);
      ld(2'h0, 8'h98, 32'hfad5ffff);
      rdc("mode load", 2'h0, 8'h98, 32'h0ad50122);
      pins(7'h00, 2'h3, 2'h3);
      ld(2'h0, 8'h98, 32'h00550000);
      pins(7'h55, 2'h3, 2'h3);
      ld(2'h2, 8'h98, 32'h0);
      pins(7'h55, 2'h3, 2'h3);
      ld(2'h1, 8'h9c, 32'h0);
      acc(2'h1, 1'b1, 8'h9c, 32'h8);
      rdc("cap load", 2'h1, 8'h9c, 32'h00000008);
      pins(7'h55, 2'h3, 2'h3);
      $display("test load done");
    end
  endtask
  task t_strap;
    begin
      do_reset(1'b1);
      rdc("mode strap", 2'h0, 8'h98, 32'h009f0122);
      pins(7'h00, 2'h3, 2'h3);
      $display("test strap done");
    end
  endtask
  initial begin
    #20000;
    mismatches = mismatches + 1;
    close_out;
  end
  initial begin
    do_reset(1'b0);
    t_reset;
    t_write;
    t_turnoff;
    t_link;
    t_load;
    t_strap;
    close_out;
  end
endmodule

// >>> common/spcr_regs.vh
// Offsets, field positions, reset values and timing counts of the port configuration bank
`ifndef SPCR_REGS_VH
`define SPCR_REGS_VH

`define SPCR_OFF_TX_MARGIN     8'h94
`define SPCR_OFF_OP_MODE       8'h98
`define SPCR_OFF_PWR_EVENT     8'h9c

`define SPCR_RST_TX_MARGIN     16'h116b
`define SPCR_RST_OP_MODE       16'h0122
`define SPCR_RST_CLK_PAIRS     7'h1f
`define SPCR_RST_LP_OPTION     4'h0
`define SPCR_RST_LINK_STATE    2'h0

`define SPCR_TXM_LSB           0
`define SPCR_TXM_MSB           15
`define SPCR_OPM_LSB           0
`define SPCR_OPM_MSB           15
`define SPCR_CLKP_LSB          16
`define SPCR_CLKP_MSB          22
`define SPCR_CLKOFF_BIT        23
`define SPCR_LPO_LSB           24
`define SPCR_LPO_MSB           27
`define SPCR_PME_CAP_BIT       0
`define SPCR_PME_OFF_BIT       1
`define SPCR_PORT_PWR_BIT      2
`define SPCR_PORT_RST_BIT      3
`define SPCR_LINK_LSB          16
`define SPCR_LINK_MSB          17

`define SPCR_STRAP_SETTLE      3'h4

`endif

// >>> core/spcr_regs_bank.v
// Device-specific configuration register bank of the three-port switch
//
// Functional notes
// R1: Read-only 16-bit transmit margin, reset 116Bh, loadable
// R2: Margin register upstream only; upper bits reserved
// R3: Operation mode word reports strap-derived mode fields
// R4: Operation mode field resets to 0122h
// R5: Clock buffer byte set via upstream port only
// R6: Global clock disable initialised from powerdown strap
// R7: Global bit zero enables, one disables outputs
// R8: Bits 22:16 gate each pair, reset 1Fh
// R9: Power event register exists downstream ports only
// R10: Read-only PME capability flag, reset 1, loadable
// R11: Writing 1 requests PME turn-off message
// R12: Port power bit drives pin when capable
// R13: Downstream port n drives general pin n-1
// R14: Port reset bit low asserts device reset
// R15: Link power state field, 00 L0 to 11 L2/L3
// R16: Read-only 4-bit low-power option, reset zero
// R17: Reserved bits read zero, writes ignored
// R18: Link state tracked continuously from link machine
`timescale 1ns/1ps
`include "spcr_regs.vh"

module spcr_regs_bank #(
  parameter NDS = 2,                                  // Number of downstream ports
  parameter PW  = 2                                   // Width of port selector
) (
  input  wire               clk_in,                   // Core clock, 250 MHz
  input  wire               rst_b_in,                 // Fundamental reset, async, active low
  input  wire               cfg_req_in,               // Configuration access request pulse
  input  wire               cfg_we_in,                // 1 write, 0 read
  input  wire [PW-1:0]      cfg_port_in,              // 0 upstream, k downstream port k
  input  wire [7:0]         cfg_addr_in,              // Register byte offset
  input  wire [3:0]         cfg_be_in,                // Byte enables
  input  wire [31:0]        cfg_wdata_in,             // Write data
  input  wire               ld_valid_in,              // Sideband or EEPROM default load strobe
  input  wire [PW-1:0]      ld_port_in,               // Port of default load
  input  wire [7:0]         ld_addr_in,               // Offset of default load
  input  wire [31:0]        ld_data_in,               // Default load data
  input  wire               clock_buffer_powerdown_strap_in, // Strap pin, asynchronous
  input  wire [2*NDS-1:0]   link_pstate_in,           // Link power state per downstream port
  input  wire [NDS-1:0]     pme_turnoff_sent_in,      // Turn-off message sent pulse per port
  output reg                cfg_ack_out,              // Access done pulse
  output reg  [31:0]        cfg_rdata_out,            // Read data, valid with ack
  output reg  [6:0]         ref_clock_out_pairs_en_out, // Reference clock pair enables
  output reg  [NDS-1:0]     port_power_gpio_out,      // Port power general pins
  output reg  [NDS-1:0]     dev_reset_b_out,          // Reset to attached device, active low
  output reg  [NDS-1:0]     pme_turnoff_req_out       // Turn-off message request level
);

  reg  [15:0]        tx_margin_q;
  reg  [15:0]        op_mode_q;
  reg  [6:0]         clk_pairs_q;
  reg                clk_off_q;
  reg  [3:0]         lp_option_q;
  reg  [NDS-1:0]     pme_cap_q;
  reg  [NDS-1:0]     pme_off_q;
  reg  [NDS-1:0]     port_pwr_q;
  reg  [NDS-1:0]     port_rst_q;
  reg  [2*NDS-1:0]   link_st_q;
  reg  [2:0]         strap_cnt_q;
  reg                strap_done_q;
  reg  [31:0]        rdata_d;
  wire               strap_lvl;
  wire               cfg_wr;
  wire               ld_up_mode;
  integer            i;
  integer            rd_idx;
  integer            pin_idx;

  function ds_hit;
    input [PW-1:0] port;
    input integer  k;
    begin
      ds_hit = (port == k + 1);
    end
  endfunction

  function is_up;
    input [PW-1:0] port;
    begin
      is_up = (port == {PW{1'b0}});
    end
  endfunction

  spcr_sync u_strap_sync (
    .clk_in    (clk_in),
    .rst_b_in  (rst_b_in),
    .pin_in    (clock_buffer_powerdown_strap_in),
    .level_out (strap_lvl)
  );

  assign cfg_wr     = cfg_req_in & cfg_we_in & cfg_be_in[0];
  assign ld_up_mode = ld_valid_in & is_up(ld_port_in) & (ld_addr_in == `SPCR_OFF_OP_MODE);

  // Upstream-only defaults: margin, clock buffer control, low-power option
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_margin_q <= `SPCR_RST_TX_MARGIN;                        // [R1]
      op_mode_q   <= `SPCR_RST_OP_MODE;                          // [R4]
      clk_pairs_q <= `SPCR_RST_CLK_PAIRS;                        // [R8]
      clk_off_q   <= 1'b0;
      lp_option_q <= `SPCR_RST_LP_OPTION;                        // [R16]
    end else begin
      if (ld_valid_in && is_up(ld_port_in) && ld_addr_in == `SPCR_OFF_TX_MARGIN) begin
        tx_margin_q <= ld_data_in[`SPCR_TXM_MSB:`SPCR_TXM_LSB];  // [R1] [R2]
      end
      if (ld_up_mode) begin
        clk_pairs_q <= ld_data_in[`SPCR_CLKP_MSB:`SPCR_CLKP_LSB]; // [R5]
        clk_off_q   <= ld_data_in[`SPCR_CLKOFF_BIT];              // [R5]
        lp_option_q <= ld_data_in[`SPCR_LPO_MSB:`SPCR_LPO_LSB];   // [R16]
      end else if (!strap_done_q && strap_cnt_q == `SPCR_STRAP_SETTLE) begin
        clk_off_q <= strap_lvl;                                   // [R6]
      end
    end
  end

  // Strap capture window after reset release
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      strap_cnt_q  <= 3'h0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      if (ld_up_mode || strap_cnt_q == `SPCR_STRAP_SETTLE) begin
        strap_done_q <= 1'b1;                                     // [R6]
      end else begin
        strap_cnt_q <= strap_cnt_q + 3'h1;
      end
    end
  end

  // Per-downstream-port power event controls
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pme_cap_q  <= {NDS{1'b1}};                                  // [R10]
      pme_off_q  <= {NDS{1'b0}};                                  // [R11]
      port_pwr_q <= {NDS{1'b1}};                                  // [R12]
      port_rst_q <= {NDS{1'b1}};                                  // [R14]
      link_st_q  <= {NDS{`SPCR_RST_LINK_STATE}};                  // [R15]
    end else begin
      link_st_q <= link_pstate_in;                                // [R18]
      for (i = 0; i < NDS; i = i + 1) begin
        if (ld_valid_in && ds_hit(ld_port_in, i) && ld_addr_in == `SPCR_OFF_PWR_EVENT) begin
          pme_cap_q[i] <= ld_data_in[`SPCR_PME_CAP_BIT];          // [R10]
        end
        // Write of 1 beats a same-cycle sent indication
        if (cfg_wr && ds_hit(cfg_port_in, i) && cfg_addr_in == `SPCR_OFF_PWR_EVENT) begin
          pme_off_q[i]  <= cfg_wdata_in[`SPCR_PME_OFF_BIT];       // [R11]
          port_pwr_q[i] <= cfg_wdata_in[`SPCR_PORT_PWR_BIT];      // [R12]
          port_rst_q[i] <= cfg_wdata_in[`SPCR_PORT_RST_BIT];      // [R14]
        end else if (pme_turnoff_sent_in[i]) begin
          pme_off_q[i] <= 1'b0;                                   // [R11]
        end
      end
    end
  end

  // Read data assembly; unmapped or reserved reads give zero
  always @* begin
    rdata_d = 32'h0000_0000;                                      // [R17]
    if (is_up(cfg_port_in) && cfg_addr_in == `SPCR_OFF_TX_MARGIN) begin
      rdata_d[`SPCR_TXM_MSB:`SPCR_TXM_LSB] = tx_margin_q;         // [R2]
    end
    if (cfg_addr_in == `SPCR_OFF_OP_MODE) begin
      rdata_d[`SPCR_OPM_MSB:`SPCR_OPM_LSB] = op_mode_q;           // [R3]
      rdata_d[`SPCR_CLKP_MSB:`SPCR_CLKP_LSB] = clk_pairs_q;
      rdata_d[`SPCR_CLKOFF_BIT] = clk_off_q;
      rdata_d[`SPCR_LPO_MSB:`SPCR_LPO_LSB] = lp_option_q;         // [R16]
    end
    for (rd_idx = 0; rd_idx < NDS; rd_idx = rd_idx + 1) begin
      if (ds_hit(cfg_port_in, rd_idx) && cfg_addr_in == `SPCR_OFF_PWR_EVENT) begin
        rdata_d[`SPCR_PME_CAP_BIT]  = pme_cap_q[rd_idx];          // [R9]
        rdata_d[`SPCR_PME_OFF_BIT]  = pme_off_q[rd_idx];
        rdata_d[`SPCR_PORT_PWR_BIT] = port_pwr_q[rd_idx];
        rdata_d[`SPCR_PORT_RST_BIT] = port_rst_q[rd_idx];
        rdata_d[`SPCR_LINK_MSB:`SPCR_LINK_LSB] = link_st_q[2*rd_idx +: 2]; // [R15]
      end
    end
  end

  // Access answer, one cycle after the request
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_ack_out   <= 1'b0;
      cfg_rdata_out <= 32'h0000_0000;
    end else begin
      cfg_ack_out <= cfg_req_in;
      if (cfg_req_in && !cfg_we_in) begin
        cfg_rdata_out <= rdata_d;
      end
    end
  end

  // Registered pin drivers
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ref_clock_out_pairs_en_out <= 7'h00;
      port_power_gpio_out        <= {NDS{1'b1}};
      dev_reset_b_out            <= {NDS{1'b0}};
      pme_turnoff_req_out        <= {NDS{1'b0}};
    end else begin
      ref_clock_out_pairs_en_out <= clk_off_q ? 7'h00 : clk_pairs_q;     // [R7] [R8]
      for (pin_idx = 0; pin_idx < NDS; pin_idx = pin_idx + 1) begin
        port_power_gpio_out[pin_idx] <= pme_cap_q[pin_idx] ? port_pwr_q[pin_idx] : 1'b1; // [R12] [R13]
      end
      dev_reset_b_out     <= port_rst_q;                                 // [R14]
      pme_turnoff_req_out <= pme_off_q;                                  // [R11]
    end
  end

endmodule

// >>> core/spcr_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module spcr_sync (
  input  wire clk_in,     // Core clock
  input  wire rst_b_in,   // Async reset, active low
  input  wire pin_in,     // Asynchronous pin level
  output reg  level_out   // Filtered synchronous level
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1_q      <= 1'b0;
      s2_q      <= 1'b0;
      s3_q      <= 1'b0;
      level_out <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Change accepted only when stages two and three agree
      if (s2_q == s3_q) begin
        level_out <= s3_q;
      end
    end
  end
endmodule
